//--- rtl/sbc_event_pkg.sv
// constants and types shared by the event notifier
package sbc_event_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam real REQUEST_TIMEOUT_MIN_MS = 5.4;
  localparam real REQUEST_TIMEOUT_MAX_MS = 6.6;
  localparam real REQUEST_PULSE_MIN_US = 10.0;
  // least time, exact in whole cycles at this rate
  localparam int REQUEST_TIMEOUT_CYCLES = int'(REQUEST_TIMEOUT_MIN_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int REQUEST_PULSE_CYCLES = int'(REQUEST_PULSE_MIN_US * 1.0e3 / CLK_PERIOD_NS);
  localparam int CNT_W = 21;

  // ****************************************
  // command port
  // ****************************************
  localparam logic [2:0] CMD_READ_ONLY = 3'h7;
  localparam logic [2:0] ADDR_WAKE = 3'h0;
  localparam logic [2:0] ADDR_TEMP = 3'h1;
  localparam logic [2:0] ADDR_SUPPLY = 3'h2;

  // ****************************************
  // source indices of the mask vector
  // ****************************************
  localparam int NUM_SRC = 13;
  localparam int NUM_STATE = 7;
  localparam int NUM_EVENT = 6;
  localparam int SRC_OTP_VCC1 = 0;
  localparam int SRC_OT_VCC2 = 1;
  localparam int SRC_OT_XCVR = 2;
  localparam int SRC_CAN_FAIL = 3;
  localparam int SRC_SECOND_REG_UNDERVOLT_FLAG = 4;
  localparam int SRC_THIRD_REG_UNDERVOLT_FLAG = 5;
  localparam int SRC_OC_VCC3 = 6;
  localparam int SRC_SPI_FAIL = 7;
  localparam int SRC_RESET = 8;
  localparam int SRC_BAD_WD = 9;
  localparam int SRC_BUS_WAKE = 10;
  localparam int SRC_PIN_WAKE = 11;
  localparam int SRC_PERIODIC_WAKE = 12;
  localparam logic [NUM_SRC-1:0] MASK_RESET = 13'h1FFF;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic CFG_RESET = 1'b0;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {REQ_IDLE, REQ_ASSERT, REQ_GAP} reqState_t;

  // analog conditions, same order as the state sources
  typedef struct packed {
    logic ocVcc3;
    logic uvVcc3;
    logic uvVcc2;
    logic canFail;
    logic otXcvr;
    logic otVcc2;
    logic otpVcc1;
  } cond_t;

  typedef struct packed {
    logic wdFailure;
    logic badWdCfg;
    logic spiFail;
    logic periodicWake;
    logic pinWake;
    logic busWake;
  } evtIn_t;

  typedef struct packed {
    logic done;
    logic [2:0] cmd;
    logic [2:0] addr;
  } spiFrame_t;

endpackage

//--- rtl/sbc_sync2.sv
// two-stage synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module sbc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] async,
  output logic [W-1:0] sync
);
  logic [W-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          stage1[i] <= 1'b0;
          sync[i] <= 1'b0;
        end else begin
          stage1[i] <= async[i];
          sync[i] <= stage1[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- rtl/sbc_state_flag.sv
// flag that latches an event, then follows its condition once read
`timescale 1ns/1ps
`default_nettype none
module sbc_state_flag (
  input wire logic clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic setEvt,
  input wire logic readClr,
  input wire logic cond,
  output logic flag
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (restart) begin
      flag <= 1'b0;
    end else if (setEvt) begin
      // set beats a read in the same cycle
      flag <= 1'b1; // [R4]
    end else if (readClr) begin
      // stays set while the condition persists
      flag <= cond; // [R4] [R15] [R16]
    end
  end
endmodule
`default_nettype wire

//--- rtl/sbc_event_notifier.sv
// event notifier: source flags, masking and the open-drain request pin
//
// Operation
// R1 - enabled event drives request pin low
// R2 - per-source mask gates pin, flag still visible
// R3 - undervoltage requests on begin and end
// R4 - state flags latch, then follow condition
// R5 - chip-failure and wake flags clear on read
// R6 - read-only to register 000 releases pin
// R7 - wakes in 000, others via summary bit
// R8 - summary clears when 001 and 010 empty
// R9 - merged sources give one low assertion
// R10 - pin low no longer than time-out
// R11 - gap of time-out between assertions
// R12 - each assertion lasts at least 10 us
// R13 - signalling only in normal or stop
// R14 - all sources enabled after reset, restart
// R15 - switch-on sets undervoltage flag
// R16 - shorted regulator keeps flag set
// R17 - switching regulator off raises nothing
// R18 - delayed second assertion survives shared read
// R19 - reset source only in development mode
// R20 - pin selects configuration during init
// R21 - development mode reports watchdog failure
// R22 - bad watchdog setting raises event
// R23 - read clears take effect at frame end
`timescale 1ns/1ps
`default_nettype none
module sbc_event_notifier
  import sbc_event_pkg::*;
#(
  parameter logic [CNT_W-1:0] TIMEOUT_CYCLES = CNT_W'(REQUEST_TIMEOUT_CYCLES)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic normalMode,
  input wire logic stopMode,
  input wire logic initMode,
  input wire logic restartMode,
  input wire logic swDevMode,
  input wire logic resetOutputPin,
  input wire cond_t condRaw,
  input wire evtIn_t evtIn,
  input wire logic reg2Enabled,
  input wire logic reg3Enabled,
  input wire logic reg2SwitchOn,
  input wire logic reg3SwitchOn,
  input wire logic maskWrite,
  input wire logic [NUM_SRC-1:0] maskData,
  input wire spiFrame_t spiFrame,
  input wire logic requestPinIn,
  output logic requestPinOut,
  output logic requestPinOe,
  output logic [7:0] wakeReg,
  output logic [7:0] tempReg,
  output logic [7:0] supplyReg,
  output logic [NUM_SRC-1:0] maskState,
  output logic cfgSelect
);

  // ****************************************
  // synchronisers
  // ****************************************
  cond_t cond;
  logic pinSync;
  logic [NUM_STATE:0] syncOut;

  sbc_sync2 #(
    .W(NUM_STATE + 1)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async({requestPinIn, condRaw}),
    .sync(syncOut)
  );

  assign cond = cond_t'(syncOut[NUM_STATE-1:0]);
  assign pinSync = syncOut[NUM_STATE];

  // ****************************************
  // qualified conditions and edges
  // ****************************************
  logic [NUM_STATE-1:0] condQual;
  logic [NUM_STATE-1:0] condPrev;
  logic reg2Prev;
  logic reg3Prev;
  logic [NUM_STATE-1:0] riseEvt;
  logic uv2Fall;
  logic uv3Fall;

  always_comb begin
    condQual = cond;
    // a regulator that is off reports no undervoltage
    condQual[SRC_SECOND_REG_UNDERVOLT_FLAG] = cond.uvVcc2 & reg2Enabled; // [R17]
    condQual[SRC_THIRD_REG_UNDERVOLT_FLAG] = cond.uvVcc3 & reg3Enabled; // [R17]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      condPrev <= '0;
      reg2Prev <= 1'b0;
      reg3Prev <= 1'b0;
    end else begin
      condPrev <= condQual;
      reg2Prev <= reg2Enabled;
      reg3Prev <= reg3Enabled;
    end
  end

  assign riseEvt = condQual & ~condPrev;
  // falling edge only counts while the regulator stays on
  assign uv2Fall = condPrev[SRC_SECOND_REG_UNDERVOLT_FLAG] & ~condQual[SRC_SECOND_REG_UNDERVOLT_FLAG]
                   & reg2Enabled & reg2Prev; // [R3] [R17]
  assign uv3Fall = condPrev[SRC_THIRD_REG_UNDERVOLT_FLAG] & ~condQual[SRC_THIRD_REG_UNDERVOLT_FLAG]
                   & reg3Enabled & reg3Prev; // [R3] [R17]

  // ****************************************
  // read clears at frame end
  // ****************************************
  logic readOnly;
  logic clrWake;
  logic clrTemp;
  logic clrSupply;

  // flags change only after chip select returns high
  assign readOnly = spiFrame.done && (spiFrame.cmd == CMD_READ_ONLY); // [R23]
  assign clrWake = readOnly && (spiFrame.addr == ADDR_WAKE); // [R6] [R23]
  assign clrTemp = readOnly && (spiFrame.addr == ADDR_TEMP);
  assign clrSupply = readOnly && (spiFrame.addr == ADDR_SUPPLY);

  // ****************************************
  // state flags
  // ****************************************
  logic [NUM_STATE-1:0] stateSet;
  logic [NUM_STATE-1:0] stateClr;
  logic [NUM_STATE-1:0] stateFlag;

  always_comb begin
    stateSet = riseEvt;
    // switch-on command forces the flag up
    stateSet[SRC_SECOND_REG_UNDERVOLT_FLAG] = riseEvt[SRC_SECOND_REG_UNDERVOLT_FLAG] | reg2SwitchOn; // [R15]
    stateSet[SRC_THIRD_REG_UNDERVOLT_FLAG] = riseEvt[SRC_THIRD_REG_UNDERVOLT_FLAG] | reg3SwitchOn; // [R15]
    stateClr = {NUM_STATE{clrSupply}};
    stateClr[SRC_OTP_VCC1] = clrTemp;
    stateClr[SRC_OT_VCC2] = clrTemp;
    stateClr[SRC_OT_XCVR] = clrTemp;
    stateClr[SRC_CAN_FAIL] = clrTemp;
  end

  genvar s;
  generate
    for (s = 0; s < NUM_STATE; s++) begin : g_state
      sbc_state_flag u_flag (
        .clk(clk),
        .rst(rst),
        .restart(restartMode),
        .setEvt(stateSet[s]),
        .readClr(stateClr[s]),
        .cond(condQual[s]),
        .flag(stateFlag[s])
      );
    end
  endgenerate

  // ****************************************
  // pure event flags
  // ****************************************
  logic [NUM_EVENT-1:0] evtSet;
  logic [NUM_EVENT-1:0] evtClr;
  logic [NUM_EVENT-1:0] evtFlag;

  always_comb begin
    evtSet[0] = evtIn.spiFail;
    // watchdog failure reported instead of reset in development mode
    evtSet[1] = evtIn.wdFailure & swDevMode; // [R19] [R21]
    evtSet[2] = evtIn.badWdCfg; // [R22]
    evtSet[3] = evtIn.busWake;
    evtSet[4] = evtIn.pinWake;
    evtSet[5] = evtIn.periodicWake;
    evtClr = {clrWake, clrWake, clrWake, clrSupply, clrSupply, clrSupply}; // [R7]
  end

  genvar e;
  generate
    for (e = 0; e < NUM_EVENT; e++) begin : g_event
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          evtFlag[e] <= 1'b0;
        end else if (restartMode) begin
          evtFlag[e] <= 1'b0;
        end else if (evtSet[e]) begin
          evtFlag[e] <= 1'b1;
        end else if (evtClr[e]) begin
          evtFlag[e] <= 1'b0; // [R5]
        end
      end
    end
  endgenerate

  // ****************************************
  // readable registers
  // ****************************************
  logic summary;
  assign summary = (|stateFlag) | (|evtFlag[2:0]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wakeReg <= FLAGS_RESET;
      tempReg <= FLAGS_RESET;
      supplyReg <= FLAGS_RESET;
    end else begin
      // summary falls only when every flag of 001 and 010 is clear
      wakeReg <= {4'h0, summary, evtFlag[5:3]}; // [R7] [R8]
      tempReg <= {4'h0, stateFlag[SRC_CAN_FAIL:SRC_OTP_VCC1]};
      supplyReg <= {2'h0, evtFlag[2:0], stateFlag[SRC_OC_VCC3:SRC_SECOND_REG_UNDERVOLT_FLAG]};
    end
  end

  // ****************************************
  // masks
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      maskState <= MASK_RESET; // [R14]
    end else if (restartMode) begin
      maskState <= MASK_RESET; // [R14]
    end else if (maskWrite) begin
      maskState <= maskData;
    end
  end

  // ****************************************
  // request sources
  // ****************************************
  logic [NUM_SRC-1:0] srcEvt;
  logic request;
  logic active;

  always_comb begin
    srcEvt[NUM_STATE-1:0] = stateSet;
    srcEvt[SRC_SECOND_REG_UNDERVOLT_FLAG] = stateSet[SRC_SECOND_REG_UNDERVOLT_FLAG] | uv2Fall; // [R3]
    srcEvt[SRC_THIRD_REG_UNDERVOLT_FLAG] = stateSet[SRC_THIRD_REG_UNDERVOLT_FLAG] | uv3Fall; // [R3]
    srcEvt[NUM_SRC-1:NUM_STATE] = evtSet;
  end

  // masked sources still record their flag above
  assign request = |(srcEvt & maskState); // [R1] [R2]
  assign active = normalMode | stopMode; // [R13]

  // ****************************************
  // request pin sequencer
  // ****************************************
  reqState_t state;
  reqState_t next_state;
  logic [CNT_W-1:0] cnt;
  logic pending;
  logic acked;
  logic start;
  logic pulseDone;
  logic timedOut;

  assign start = (state == REQ_IDLE) && active && (pending || request); // [R9] [R11]
  assign pulseDone = cnt >= CNT_W'(REQUEST_PULSE_CYCLES - 1); // [R12]
  assign timedOut = cnt >= (TIMEOUT_CYCLES - CNT_W'(1)); // [R10] [R11]

  always_comb begin
    next_state = state;
    unique case (state)
      REQ_IDLE: begin
        if (start) begin
          next_state = REQ_ASSERT; // [R1]
        end
      end
      REQ_ASSERT: begin
        if (!active) begin
          next_state = REQ_IDLE; // [R13]
        end else if ((pulseDone && (acked || clrWake)) || timedOut) begin
          next_state = REQ_GAP; // [R6] [R10] [R12]
        end
      end
      REQ_GAP: begin
        if (timedOut) begin
          next_state = REQ_IDLE; // [R11]
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= REQ_IDLE;
    end else if (restartMode) begin
      state <= REQ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else if (next_state != state) begin
      cnt <= '0;
    end else if (state != REQ_IDLE) begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  // acknowledge seen during the minimum pulse is held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acked <= 1'b0;
    end else if (state != REQ_ASSERT) begin
      acked <= 1'b0;
    end else if (clrWake) begin
      acked <= 1'b1; // [R6] [R12]
    end
  end

  // events arriving while asserted or in the gap wait here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending <= 1'b0;
    end else if (restartMode) begin
      pending <= 1'b0;
    end else if (start) begin
      pending <= 1'b0; // [R9]
    end else if (request) begin
      pending <= 1'b1; // [R11] [R18]
    end
  end

  // ****************************************
  // configuration capture
  // ****************************************
  logic cfgWindow;
  logic cfgSample;
  logic cfgWindowPrev;

  assign cfgWindow = initMode && !resetOutputPin; // [R20]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfgSample <= CFG_RESET;
      cfgWindowPrev <= 1'b0;
    end else begin
      cfgWindowPrev <= cfgWindow;
      if (cfgWindow) begin
        cfgSample <= pinSync; // [R20]
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfgSelect <= CFG_RESET;
    end else if (cfgWindowPrev && !cfgWindow && initMode) begin
      // stored as the reset output goes high
      cfgSelect <= cfgSample; // [R20]
    end
  end

  // ****************************************
  // open-drain pin drive
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      requestPinOut <= 1'b0;
      requestPinOe <= 1'b0;
    end else begin
      requestPinOut <= 1'b0;
      // released from the cycle after the pin starts acting as configuration input
      requestPinOe <= (next_state == REQ_ASSERT) && !cfgWindow && !restartMode; // [R1] [R20]
    end
  end

endmodule
`default_nettype wire

//--- dv/sbc_event_notifier_checker.sv
// assertion checker bound to the event notifier
`timescale 1ns/1ps
`default_nettype none
module sbc_event_notifier_checker
  import sbc_event_pkg::*;
#(
  parameter logic [CNT_W-1:0] TIMEOUT_CYCLES = CNT_W'(REQUEST_TIMEOUT_CYCLES)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic normalMode,
  input wire logic stopMode,
  input wire logic initMode,
  input wire logic restartMode,
  input wire logic resetOutputPin,
  input wire evtIn_t evtIn,
  input wire logic maskWrite,
  input wire logic [NUM_SRC-1:0] maskData,
  input wire logic requestPinOe,
  input wire logic [7:0] wakeReg,
  input wire logic [7:0] tempReg,
  input wire logic [7:0] supplyReg,
  input wire logic [NUM_SRC-1:0] maskState
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************
  // helper counters
  // ****************************************
  localparam int MAX_LOW = int'(TIMEOUT_CYCLES) * 11 / 9;
  logic [CNT_W:0] hiCnt;
  logic [CNT_W:0] loCnt;
  logic gapOwed;
  logic active;
  assign active = normalMode || stopMode;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hiCnt <= '0;
      loCnt <= '0;
    end else begin
      hiCnt <= requestPinOe ? hiCnt + 1'b1 : '0;
      loCnt <= requestPinOe ? '0 : loCnt + 1'b1;
    end
  end
  // release inside a mode owes a spacing gap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gapOwed <= 1'b0;
    end else if (!active || restartMode) begin
      gapOwed <= 1'b0;
    end else if (!requestPinOe && hiCnt != '0) begin
      gapOwed <= 1'b1;
    end else if (requestPinOe) begin
      gapOwed <= 1'b0;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  a_pin_mode: assert property (!active |=> !requestPinOe)
    else $error("pin driven outside normal or stop");
  a_pin_start: assert property (evtIn.busWake && maskState[SRC_BUS_WAKE] && active
      && !gapOwed && !initMode && !restartMode && !requestPinOe ##1 active && !restartMode
      |-> ##[0:1] requestPinOe)
    else $error("unmasked event gave no request");
  a_pulse_min: assert property ($fell(requestPinOe) && $past(active) && !$past(restartMode)
      |-> hiCnt >= CNT_W'(REQUEST_PULSE_CYCLES))
    else $error("request shorter than least width");
  a_pulse_max: assert property (hiCnt <= MAX_LOW)
    else $error("request held past time-out");
  a_gap_min: assert property ($rose(requestPinOe) && gapOwed |-> loCnt >= TIMEOUT_CYCLES)
    else $error("requests spaced too closely");
  a_cfg_window: assert property ((initMode && !resetOutputPin)[*2] |-> !requestPinOe)
    else $error("pin driven in configuration window");
  a_summary_or: assert property (wakeReg[7:3] == {4'h0, |{tempReg, supplyReg}})
    else $error("summary bit disagrees with flags");
  a_mask_load: assert property (maskWrite && !restartMode |=> maskState == $past(maskData))
    else $error("mask not loaded");
  a_restart_mask: assert property (restartMode |=> maskState == MASK_RESET)
    else $error("restart left sources disabled");
  a_wake_flag: assert property (evtIn.busWake && !restartMode |-> ##2 wakeReg[0])
    else $error("wake event not recorded");
endmodule
bind sbc_event_notifier sbc_event_notifier_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (
  .clk, .rst, .normalMode, .stopMode, .initMode, .restartMode, .resetOutputPin, .evtIn,
  .maskWrite, .maskData, .requestPinOe, .wakeReg, .tempReg, .supplyReg, .maskState
);
`default_nettype wire

//--- dv/sbc_host_model.sv
// host microcontroller model answering requests over the command port
`timescale 1ns/1ps
`default_nettype none
module sbc_host_model
  import sbc_event_pkg::*;
(
  input wire logic clk,
  input wire logic requestPinOe,
  input wire logic wakeSummary,
  input wire logic pullUp,
  input wire logic ackEn,
  input wire logic [7:0] ackDelay,
  output var spiFrame_t spiFrame,
  output logic pinLevel
);
  // open-drain pin with its external resistor
  assign pinLevel = requestPinOe ? 1'b0 : pullUp;
  task automatic spi_read(input logic [2:0] addr);
    @(posedge clk);
    #1;
    spiFrame = '{done: 1'b1, cmd: CMD_READ_ONLY, addr: addr};
    @(posedge clk);
    #1;
    spiFrame = '{done: 1'b0, cmd: ~CMD_READ_ONLY, addr: ~addr};
  endtask
  initial begin
    spiFrame = '{done: 1'b0, cmd: 3'h0, addr: 3'h5};
    forever begin
      @(posedge clk);
      #1;
      if (ackEn && requestPinOe) begin
        repeat (ackDelay) @(posedge clk);
        spi_read(ADDR_WAKE);
        if (wakeSummary) begin
          spi_read(ADDR_TEMP);
          spi_read(ADDR_SUPPLY);
        end
        wait (!requestPinOe || !ackEn);
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/tb.sv
// self-checking testbench for the event notifier
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sbc_event_pkg::*;
  localparam int TO = 3000;
  localparam int PULSE = REQUEST_PULSE_CYCLES;
  logic clk, rst, normalMode, stopMode, initMode, restartMode, swDevMode, resetOutputPin;
  logic reg2Enabled, reg3Enabled, reg2SwitchOn, reg3SwitchOn, maskWrite, pullUp, ackEn;
  logic requestPinIn, requestPinOut, requestPinOe, cfgSelect;
  logic [NUM_SRC-1:0] maskData, maskState;
  logic [7:0] wakeReg, tempReg, supplyReg, ackDelay;
  cond_t condRaw;
  evtIn_t evtIn;
  spiFrame_t spiFrame;
  int fails = 0;
  int tests_run = 0;
  int n;
  sbc_event_notifier #(.TIMEOUT_CYCLES(CNT_W'(TO))) dut (.clk, .rst, .normalMode, .stopMode,
    .initMode, .restartMode, .swDevMode, .resetOutputPin, .condRaw, .evtIn, .reg2Enabled,
    .reg3Enabled, .reg2SwitchOn, .reg3SwitchOn, .maskWrite, .maskData, .spiFrame,
    .requestPinIn, .requestPinOut, .requestPinOe, .wakeReg, .tempReg, .supplyReg, .maskState,
    .cfgSelect);
  sbc_host_model host (.clk, .requestPinOe, .wakeSummary(wakeReg[3]), .pullUp, .ackEn,
    .ackDelay, .spiFrame, .pinLevel(requestPinIn));
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // counts cycles until the pin drive reaches a level
  task automatic wait_oe(input logic lvl, input int limit);
    n = 0;
    while (requestPinOe !== lvl && n < limit) begin
      tick(1);
      n++;
    end
    check(requestPinOe, lvl);
  endtask
  task automatic pulse_evt(input logic [5:0] e);
    evtIn = evtIn_t'(e);
    tick(1);
    evtIn = '0;
    tick(1);
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ****************************************
  // clock, watchdog, tests
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #(80000 * 4);
    fails++;
    stop_test();
  end
  initial begin
    {stopMode, initMode, restartMode, swDevMode, condRaw, evtIn, reg2Enabled, ackEn} = '0;
    {reg3Enabled, reg2SwitchOn, reg3SwitchOn, maskWrite, maskData, ackDelay} = '0;
    {rst, normalMode, resetOutputPin, pullUp} = 4'hF;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(2);
    check(maskState, MASK_RESET);
    check({wakeReg, tempReg}, 16'h0000);
    $display("test reset done");
    ackEn = 1'b1;
    pulse_evt(6'h01);
    tick(2);
    check({requestPinOe, requestPinOut}, 2'b10);
    wait_oe(1'b0, PULSE + 100);
    check(n >= PULSE - 4, 1'b1);
    check(n <= PULSE, 1'b1);
    check(wakeReg, 8'h00);
    $display("test prompt read done");
    ackEn = 1'b0;
    pulse_evt(6'h02);
    pulse_evt(6'h04);
    wait_oe(1'b1, 2 * TO);
    check(n >= TO - 10, 1'b1);
    check(wakeReg[2:0], 3'b110);
    pulse_evt(6'h02);
    wait_oe(1'b0, 2 * TO);
    check(n >= TO - 10 && n <= TO * 11 / 9, 1'b1);
    check(wakeReg[2:0], 3'b110);
    host.spi_read(ADDR_WAKE);
    tick(3);
    check(wakeReg, 8'h00);
    wait_oe(1'b1, 2 * TO);
    check({requestPinOe, wakeReg}, 9'h100);
    host.spi_read(ADDR_WAKE);
    wait_oe(1'b0, PULSE + 100);
    tick(TO + 10);
    $display("test time-out and gap done");
    maskData = MASK_RESET & ~(13'h1 << SRC_BUS_WAKE);
    maskWrite = 1'b1;
    tick(1);
    maskWrite = 1'b0;
    pulse_evt(6'h01);
    tick(50);
    check({requestPinOe, wakeReg[0], maskState}, {2'b01, maskData});
    host.spi_read(ADDR_WAKE);
    $display("test mask done");
    condRaw.otVcc2 = 1'b1;
    tick(6);
    check({wakeReg[3], tempReg}, 9'h102);
    condRaw.otVcc2 = 1'b0;
    tick(6);
    check(tempReg, 8'h02);
    host.spi_read(ADDR_TEMP);
    tick(3);
    check({wakeReg[3], tempReg}, 9'h000);
    $display("test state flag done");
    normalMode = 1'b0;
    tick(2);
    check(requestPinOe, 1'b0);
    pulse_evt(6'h30);
    tick(3);
    check({requestPinOe, supplyReg[5:4]}, 3'b010);
    swDevMode = 1'b1;
    pulse_evt(6'h20);
    tick(3);
    check(supplyReg[5:4], 2'b11);
    host.spi_read(ADDR_SUPPLY);
    swDevMode = 1'b0;
    $display("test modes done");
    {stopMode, ackEn, reg2Enabled} = 3'h7;
    ackDelay = 8'h64;
    // leftover request from the inactive period
    wait_oe(1'b1, 20);
    wait_oe(1'b0, PULSE + 200);
    tick(TO + 10);
    condRaw.uvVcc2 = 1'b1;
    wait_oe(1'b1, 20);
    wait_oe(1'b0, PULSE + 200);
    tick(TO + 10);
    condRaw.uvVcc2 = 1'b0;
    wait_oe(1'b1, 20);
    wait_oe(1'b0, PULSE + 200);
    tick(TO + 10);
    {ackEn, reg2Enabled} = 2'b00;
    tick(1);
    condRaw.uvVcc2 = 1'b1;
    tick(20);
    check(requestPinOe, 1'b0);
    reg3Enabled = 1'b1;
    reg3SwitchOn = 1'b1;
    tick(1);
    reg3SwitchOn = 1'b0;
    tick(3);
    check({requestPinOe, supplyReg[1]}, 2'b11);
    host.spi_read(ADDR_SUPPLY);
    tick(3);
    check(supplyReg[1], 1'b0);
    condRaw.uvVcc3 = 1'b1;
    tick(6);
    host.spi_read(ADDR_SUPPLY);
    tick(3);
    check(supplyReg[1], 1'b1);
    $display("test regulators done");
    restartMode = 1'b1;
    tick(2);
    restartMode = 1'b0;
    tick(2);
    check({maskState, requestPinOe}, {MASK_RESET, 1'b0});
    {normalMode, stopMode, initMode, resetOutputPin} = 4'h2;
    tick(6);
    resetOutputPin = 1'b1;
    tick(4);
    check({cfgSelect, requestPinOe}, 2'b10);
    $display("test restart and config done");
    stop_test();
  end
endmodule
`default_nettype wire
